// ### design/aor_outlier.v
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "aor_regs.vh"

module aor_outlier (
  input  wire                  clk_sys_in,
  input  wire                  rst_in,
  input  wire                  ce_in,
  input  wire                  psel_in,
  input  wire                  penable_in,
  input  wire                  pwrite_in,
  input  wire [7:0]            paddr_in,
  input  wire [31:0]           pwdata_in,
  input  wire [3:0]            pstrb_in,
  output wire [31:0]           prdata_out,
  output wire                  pready_out,
  output wire                  pslverr_out,
  input  wire                  smp_valid_in,
  input  wire [`AOR_SMP_W-1:0] smp_data_in,
  output wire                  out_valid_out,
  output wire [`AOR_SMP_W-1:0] out_data_out,
  output wire                  out_outlier_out,
  output wire                  active_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  function [`AOR_SMP_W-1:0] aor_absdiff;
    input [`AOR_SMP_W-1:0] a;
    input [`AOR_SMP_W-1:0] b;
    begin
      if (a >= b) begin
        aor_absdiff = a - b;
      end else begin
        aor_absdiff = b - a;
      end
    end
  endfunction

  function [`AOR_LPF_W-1:0] aor_init_val;
    input [1:0] code;
    begin
      case (code)
        2'h0:    aor_init_val = `AOR_LPF_INIT0;
        2'h1:    aor_init_val = `AOR_LPF_INIT1;
        2'h2:    aor_init_val = `AOR_LPF_INIT2;
        default: aor_init_val = `AOR_LPF_INIT3;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------

  reg  [7:0]            cfg_q;
  reg  [31:0]           prdata_q;
  reg                   slverr_q;
  reg  [`AOR_SMP_W-1:0] prev_q;
  reg  [`AOR_SMP_W-1:0] hist0_q;
  reg  [`AOR_SMP_W-1:0] hist1_q;
  reg  [`AOR_SMP_W-1:0] hist2_q;
  reg  [`AOR_SMP_W-1:0] hist3_q;
  reg  [2:0]            hcnt_q;
  reg  [2:0]            hcnt_d;
  reg  [`AOR_LPF_W-1:0] lpf_q;
  reg  [`AOR_LPF_W-1:0] lpf_d;
  reg  [15:0]           ocnt_q;
  reg  [15:0]           ocnt_d;
  reg  [`AOR_SMP_W-1:0] err_q;
  reg  [`AOR_THR_W-1:0] thr_q;
  reg                   ovalid_q;
  reg  [`AOR_SMP_W-1:0] odata_q;
  reg                   oflag_q;

  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------

  wire                  fix_on;
  wire                  prediction_order;
  wire [1:0]            lowpass_time_constant;
  wire [1:0]            lowpass_initial_value;
  wire [1:0]            threshold_multiplier;

  assign fix_on                = cfg_q[`AOR_EN_BIT];
  assign prediction_order      = cfg_q[`AOR_ORDER_BIT];
  assign lowpass_time_constant = cfg_q[`AOR_TC_HI:`AOR_TC_LO];
  assign lowpass_initial_value = cfg_q[`AOR_INIT_HI:`AOR_INIT_LO];
  assign threshold_multiplier  = cfg_q[`AOR_MULT_HI:`AOR_MULT_LO];

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------

  wire                  access_ph;
  wire                  aligned;
  wire [5:0]            idx;
  wire                  primed;
  wire                  capture;
  wire                  done;
  reg                   bus_q;
  reg                   bus_d;
  reg                   hit;
  reg  [31:0]           rd_word;
  wire                  wr_cfg;
  wire                  wr_stat;

  assign access_ph = psel_in & penable_in;
  assign aligned   = (paddr_in[1:0] == 2'b00);
  assign idx       = paddr_in[7:2];

  // freezing the clock enable stretches the access phase
  assign pready_out  = done;
  assign pslverr_out = done & slverr_q;
  assign prdata_out  = prdata_q;

  assign wr_cfg  = done & pwrite_in & ~slverr_q & (idx == `AOR_CFG_IDX) & pstrb_in[0];
  assign wr_stat = done & pwrite_in & ~slverr_q & (idx == `AOR_STAT_IDX) & (|pstrb_in);

  always @* begin
    hit     = 1'b0;
    rd_word = 32'h0000_0000;
    if (aligned) begin
      case (idx)
        `AOR_CFG_IDX: begin
          hit          = 1'b1;
          rd_word[7:0] = cfg_q;
        end
        `AOR_STAT_IDX: begin
          hit                        = 1'b1;
          rd_word[15:0]              = ocnt_q;
          rd_word[`AOR_STAT_ACT_BIT] = fix_on;
          rd_word[`AOR_STAT_PRM_BIT] = primed;
        end
        `AOR_LPF_IDX: begin
          hit                       = 1'b1;
          rd_word[`AOR_LPF_W-1:0]   = lpf_q;
        end
        `AOR_ERR_IDX: begin
          hit                       = 1'b1;
          rd_word[`AOR_SMP_W-1:0]   = err_q;
        end
        `AOR_THR_IDX: begin
          hit                       = 1'b1;
          rd_word[`AOR_THR_W-1:0]   = thr_q;
        end
        default: begin
          hit     = 1'b0;
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // apb phase tracking
  // ---------------------------------------------------------------

  localparam BUS_WAIT   = 1'b0;
  localparam BUS_LOADED = 1'b1;

  // a setup cycle lost to a low clock enable is captured in the first
  // enabled access cycle instead: one wait state, never stale read data
  assign capture = ce_in & psel_in & (bus_q == BUS_WAIT);
  assign done    = ce_in & access_ph & (bus_q == BUS_LOADED);

  always @* begin
    case (bus_q)
      BUS_WAIT: begin
        bus_d = capture ? BUS_LOADED : BUS_WAIT;
      end
      BUS_LOADED: begin
        bus_d = (done | ~psel_in) ? BUS_WAIT : BUS_LOADED;
      end
      default: begin
        bus_d = BUS_WAIT;
      end
    endcase
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bus_q <= BUS_WAIT;
    end else if (ce_in) begin
      bus_q <= bus_d;
    end
  end

  // read data and error are captured in the setup cycle so both leave flops
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (capture) begin
      prdata_q <= pwrite_in ? 32'h0000_0000 : rd_word;
      slverr_q <= ~hit;
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_q <= `AOR_CFG_RST;
    end else if (wr_cfg) begin
      cfg_q <= pwdata_in[7:0];
    end
  end

  // ---------------------------------------------------------------
  // prediction and detection
  // ---------------------------------------------------------------

  wire                  take;
  wire [`AOR_SMP_W-1:0] pred;
  wire [`AOR_SMP_W-1:0] est_err;
  wire [`AOR_THR_W-1:0] lpf_int_ext;
  wire [2:0]            mult_sh;
  wire [`AOR_THR_W-1:0] outlier_threshold;
  wire                  is_outlier;
  wire [`AOR_SMP_W-1:0] result;

  assign take = ce_in & smp_valid_in;

  aor_predict u_predict (
    .hist0_in (hist0_q),
    .hist2_in (hist2_q),
    .hist3_in (hist3_q),
    .prev_in  (prev_q),
    .order_in (prediction_order),
    .pred_out (pred)
  );

  assign est_err = aor_absdiff(smp_data_in, pred);

  // integer part of the lowpass state, scaled by 4..32
  assign lpf_int_ext       = {{(`AOR_THR_W-`AOR_SMP_W){1'b0}}, lpf_q[`AOR_LPF_W-1:`AOR_FRAC_W]};
  assign mult_sh           = {1'b0, threshold_multiplier} + `AOR_MULT_BASE;
  assign outlier_threshold = lpf_int_ext << mult_sh;

  // no replacement until the predictor has a full history since enable
  assign primed = prediction_order ? (hcnt_q == `AOR_HIST_FULL) : (hcnt_q != 3'h0);

  assign is_outlier = fix_on & primed &
                      ({{(`AOR_THR_W-`AOR_SMP_W){1'b0}}, est_err} > outlier_threshold);

  assign result = is_outlier ? pred : smp_data_in;

  // ---------------------------------------------------------------
  // lowpass of the estimation error
  // ---------------------------------------------------------------

  wire [2:0]            tc_sh;
  wire signed [25:0]    lpf_diff;
  wire signed [25:0]    lpf_step;
  wire signed [25:0]    lpf_sum;

  assign tc_sh    = {1'b0, lowpass_time_constant} + `AOR_TC_BASE;
  assign lpf_diff = $signed({1'b0, est_err, {`AOR_FRAC_W{1'b0}}}) - $signed({1'b0, lpf_q});
  assign lpf_step = lpf_diff >>> tc_sh;
  assign lpf_sum  = $signed({1'b0, lpf_q}) + lpf_step;

  always @* begin
    if (!fix_on) begin
      lpf_d = aor_init_val(lowpass_initial_value);
    end else if (take) begin
      lpf_d = lpf_sum[`AOR_LPF_W-1:0];
    end else begin
      lpf_d = lpf_q;
    end
  end

  // history counter restarts whenever the function is off
  always @* begin
    if (!fix_on) begin
      hcnt_d = 3'h0;
    end else if (take && hcnt_q != `AOR_HIST_FULL) begin
      hcnt_d = hcnt_q + 3'h1;
    end else begin
      hcnt_d = hcnt_q;
    end
  end

  // a clear that meets an outlier keeps that outlier
  always @* begin
    ocnt_d = ocnt_q;
    if (wr_stat) begin
      ocnt_d = 16'h0000;
    end
    if (take && is_outlier) begin
      ocnt_d = wr_stat ? 16'h0001 : ocnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // sample pipeline
  // ---------------------------------------------------------------

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q   <= {`AOR_SMP_W{1'b0}};
      hist0_q  <= {`AOR_SMP_W{1'b0}};
      hist1_q  <= {`AOR_SMP_W{1'b0}};
      hist2_q  <= {`AOR_SMP_W{1'b0}};
      hist3_q  <= {`AOR_SMP_W{1'b0}};
      err_q    <= {`AOR_SMP_W{1'b0}};
      thr_q    <= {`AOR_THR_W{1'b0}};
      odata_q  <= {`AOR_SMP_W{1'b0}};
      oflag_q  <= 1'b0;
      ovalid_q <= 1'b0;
    end else if (ce_in) begin
      ovalid_q <= take;
      if (take) begin
        prev_q  <= smp_data_in;
        hist0_q <= hist1_q;
        hist1_q <= hist2_q;
        hist2_q <= hist3_q;
        hist3_q <= result;
        err_q   <= est_err;
        thr_q   <= outlier_threshold;
        odata_q <= result;
        oflag_q <= is_outlier;
      end
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      lpf_q  <= `AOR_LPF_INIT0;
      hcnt_q <= 3'h0;
      ocnt_q <= 16'h0000;
    end else if (ce_in) begin
      lpf_q  <= lpf_d;
      hcnt_q <= hcnt_d;
      ocnt_q <= ocnt_d;
    end
  end

  assign out_valid_out   = ovalid_q;
  assign out_data_out    = odata_q;
  assign out_outlier_out = oflag_q;
  assign active_out      = fix_on;

endmodule // aor_outlier

// ### design/aor_regs.vh
// Contract
// - replacement off after reset; on via bit7
// - error is magnitude of sample minus prediction
// - error strictly above threshold marks outlier
// - order zero predicts previous converted sample
// - order one extrapolates four recent outputs
// - error feeds first-order lowpass, once per sample
// - threshold is lowpass times selected multiplier
// - time-constant field sets lowpass time constant
// - init field selects lowpass value at initialization
// - outlier outputs prediction, else input unchanged
`ifndef AOR_REGS_VH
`define AOR_REGS_VH

`define AOR_SMP_W        19
`define AOR_FRAC_W       6
`define AOR_LPF_W        25
`define AOR_THR_W        24

`define AOR_CFG_IDX      6'h16
`define AOR_STAT_IDX     6'h17
`define AOR_LPF_IDX      6'h18
`define AOR_ERR_IDX      6'h19
`define AOR_THR_IDX      6'h1a

`define AOR_CFG_RST      8'h00
`define AOR_EN_BIT       7
`define AOR_ORDER_BIT    6
`define AOR_TC_HI        5
`define AOR_TC_LO        4
`define AOR_INIT_HI      3
`define AOR_INIT_LO      2
`define AOR_MULT_HI      1
`define AOR_MULT_LO      0

`define AOR_MULT_BASE    3'h2
`define AOR_TC_BASE      3'h3
`define AOR_HIST_FULL    3'h4

`define AOR_LPF_INIT0    25'h0000000
`define AOR_LPF_INIT1    25'h0000400
`define AOR_LPF_INIT2    25'h0001000
`define AOR_LPF_INIT3    25'h0004000

`define AOR_STAT_ACT_BIT 16
`define AOR_STAT_PRM_BIT 17

`endif

// ### design/aor_predict.v
`timescale 1ns/1ps
`include "aor_regs.vh"

module aor_predict (
  input  wire [`AOR_SMP_W-1:0] hist0_in,
  input  wire [`AOR_SMP_W-1:0] hist2_in,
  input  wire [`AOR_SMP_W-1:0] hist3_in,
  input  wire [`AOR_SMP_W-1:0] prev_in,
  input  wire                  order_in,
  output reg  [`AOR_SMP_W-1:0] pred_out
);

  // straight-line fit at x=0..3, evaluated at x=4: (2*y3 + y2 - y0) / 2
  wire signed [21:0] ext;
  wire signed [21:0] half;

  assign ext  = $signed({2'b00, hist3_in, 1'b0}) + $signed({3'b000, hist2_in})
              - $signed({3'b000, hist0_in}) + 22'sd1;
  assign half = ext >>> 1;

  always @* begin
    if (!order_in) begin
      pred_out = prev_in;
    end else if (half < 22'sd0) begin
      pred_out = {`AOR_SMP_W{1'b0}};
    end else if (half > $signed({3'b000, {`AOR_SMP_W{1'b1}}})) begin
      pred_out = {`AOR_SMP_W{1'b1}};
    end else begin
      pred_out = half[`AOR_SMP_W-1:0];
    end
  end

endmodule // aor_predict

// ### sim/aor_adc_model.sv
`timescale 1ns/1ps
`include "aor_regs.vh"
module aor_adc_model (
  input  wire                  clk_sys_in,
  output reg                   smp_valid_out,
  output reg [`AOR_SMP_W-1:0]  smp_data_out
);
  initial begin
    smp_valid_out = 1'b0;
    smp_data_out  = 19'h0;
  end
  // one conversion strobe per call; data line scrambled once strobe drops
  task send(input [`AOR_SMP_W-1:0] v);
    @(posedge clk_sys_in);
    smp_valid_out <= 1'b1;
    smp_data_out  <= v;
    @(posedge clk_sys_in);
    smp_valid_out <= 1'b0;
    smp_data_out  <= ~v;
  endtask
endmodule // aor_adc_model

// ### sim/aor_outlier_sva.sv
`timescale 1ns/1ps
`include "aor_regs.vh"
module aor_outlier_sva (
  input wire                  clk_sys_in,
  input wire                  rst_in,
  input wire                  ce_in,
  input wire                  psel_in,
  input wire                  penable_in,
  input wire                  pwrite_in,
  input wire [7:0]            paddr_in,
  input wire [31:0]           pwdata_in,
  input wire [3:0]            pstrb_in,
  input wire [31:0]           prdata_out,
  input wire                  pready_out,
  input wire                  pslverr_out,
  input wire                  smp_valid_in,
  input wire [`AOR_SMP_W-1:0] smp_data_in,
  input wire                  out_valid_out,
  input wire [`AOR_SMP_W-1:0] out_data_out,
  input wire                  out_outlier_out,
  input wire                  active_out
);
  reg  [7:0]            cfg_q;
  reg  [`AOR_SMP_W-1:0] s1_q;
  reg  [`AOR_SMP_W-1:0] s2_q;
  wire                  smp = smp_valid_in & ce_in;
  wire wr_cfg = psel_in & penable_in & pwrite_in & pready_out & pstrb_in[0] & (paddr_in == 8'h58);
  // shadow of config and last two taken samples, for prediction checks
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_q <= 8'h00;
      s1_q  <= 19'h0;
      s2_q  <= 19'h0;
    end else begin
      if (wr_cfg)
        cfg_q <= pwdata_in[7:0];
      if (smp) begin
        s1_q <= smp_data_in;
        s2_q <= s1_q;
      end
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  a_out_pulse: assert property (smp |=> out_valid_out) else $error("no output after sample");
  a_no_pulse: assert property (!smp |=> !out_valid_out) else $error("spurious output strobe");
  a_off_pass: assert property (smp && !active_out |=> out_data_out == $past(smp_data_in) && !out_outlier_out)
    else $error("disabled block altered sample");
  a_keep_input: assert property (out_valid_out && !out_outlier_out |-> out_data_out == s1_q)
    else $error("clean sample not passed unchanged");
  a_replace_diff: assert property (out_valid_out && out_outlier_out |-> out_data_out != s1_q)
    else $error("outlier with zero error");
  a_replace_prev: assert property (out_valid_out && out_outlier_out && !cfg_q[6] |-> out_data_out == s2_q)
    else $error("order zero replacement not previous sample");
  a_on_only: assert property (out_valid_out && out_outlier_out |-> $past(active_out))
    else $error("replacement while disabled");
  a_active_cfg: assert property (active_out == cfg_q[7]) else $error("active flag not config bit");
  a_data_hold: assert property (!out_valid_out |-> $stable(out_data_out) && $stable(out_outlier_out))
    else $error("output changed between samples");
  c_rep_o0: cover property (out_valid_out && out_outlier_out && !cfg_q[6]);
  c_rep_o1: cover property (out_valid_out && out_outlier_out && cfg_q[6]);
  c_enable: cover property (wr_cfg && pwdata_in[7]);
endmodule // aor_outlier_sva
bind aor_outlier aor_outlier_sva chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .smp_valid_in(smp_valid_in),
  .smp_data_in(smp_data_in), .out_valid_out(out_valid_out), .out_data_out(out_data_out),
  .out_outlier_out(out_outlier_out), .active_out(active_out));

// ### sim/ambient_outlier_replacer_test.sv
`timescale 1ns/1ps
`include "aor_regs.vh"
module ambient_outlier_replacer_test;
  reg         clk_sys_in, rst_in, ce_in, psel, penable, pwrite, e;
  reg  [7:0]  paddr, cfg, k;
  reg  [31:0] pwdata, r;
  reg  [18:0] prev, ld, y [0:3];
  reg  [23:0] lt;
  reg  [24:0] lpf;
  reg  [19:0] x, expq [$];
  wire [31:0] prdata;
  wire        pready, pslverr, smp_v, ov, oo, act;
  wire [18:0] smp_d, od;
  integer     err_total, n_tests, cnt, base, nout;
  aor_outlier dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .smp_valid_in(smp_v), .smp_data_in(smp_d), .out_valid_out(ov),
    .out_data_out(od), .out_outlier_out(oo), .active_out(act));
  aor_adc_model src (.clk_sys_in(clk_sys_in), .smp_valid_out(smp_v), .smp_data_out(smp_d));
  task chk(input [31:0] seen, input [31:0] want);
    n_tests = n_tests + 1;
    if (seen !== want) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task report_and_stop;
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer i;
    @(posedge clk_sys_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys_in);
      i = i + 1;
    end while (pready !== 1'b1 && i < 40);
    if (i >= 40) begin
      err_total = err_total + 1;
      report_and_stop;
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  function [24:0] linit(input [1:0] c);
    linit = (c == 2'd0) ? 25'h0 : 25'h40 << (2 * c + 2);
  endfunction
  function [18:0] pred(input o);
    integer t;
    t = (2 * int'(y[3]) + int'(y[2]) - int'(y[0]) + 1) >>> 1;
    if (t < 0) t = 0;
    if (t > 524287) t = 524287;
    pred = o ? t[18:0] : prev;
  endfunction
  // reference: threshold uses lowpass before this sample's update
  task model(input [18:0] s);
    reg [18:0] p, d, o;
    reg hit;
    integer df;
    p = pred(cfg[6]);
    df = int'(s) - int'(p);
    d = (df < 0) ? -df : df;
    lt = (lpf >> 6) << (cfg[1:0] + 2);
    ld = d;
    hit = cfg[7] && cnt >= (cfg[6] ? 4 : 1) && d > lt;
    if (hit) nout = nout + 1;
    o = hit ? p : s;
    if (cfg[7]) begin
      lpf = lpf + ((int'({d, 6'h0}) - int'(lpf)) >>> (cfg[5:4] + 3));
      cnt = cnt + 1;
    end
    prev = s;
    y[0] = y[1]; y[1] = y[2]; y[2] = y[3]; y[3] = o;
    expq.push_back({hit, o});
  endtask
  task wcfg(input [7:0] v);
    apb(1'b1, 8'h58, {24'h0, v});
    chk(e, 0);
    cfg = v;
    if (!v[7]) begin
      lpf = linit(v[3:2]);
      cnt = 0;
    end
  endtask
  // slow drift with occasional large excursions
  task stream(input integer n);
    integer i;
    reg [18:0] s;
    for (i = 0; i < n; i = i + 1) begin
      base = base + ($urandom % 64) - 32;
      s = base + (($urandom % 8 == 0) ? 100000 : 0);
      model(s);
      src.send(s);
    end
  endtask
  // outputs leave flops on the rising edge, so look at them mid-cycle
  always @(negedge clk_sys_in) begin
    if (ov === 1'b1) begin
      if (expq.size() == 0)
        chk(32'h1, 32'h0);
      else begin
        x = expq.pop_front();
        chk({oo, od}, x);
      end
    end
  end
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    err_total = err_total + 1;
    report_and_stop;
  end
  initial begin
    rst_in = 1'b1; ce_in = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    err_total = 0; n_tests = 0; cnt = 0; base = 200000; cfg = 8'h0; lpf = 25'h0; prev = 19'h0;
    nout = 0;
    y[0] = 19'h0; y[1] = 19'h0; y[2] = 19'h0; y[3] = 19'h0;
    void'($urandom(32'h2cf1));
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    apb(1'b0, 8'h58, 32'h0);
    chk(r, 32'h0);
    chk(act, 0);
    apb(1'b0, 8'h70, 32'h0);
    chk(e, 1);
    apb(1'b0, 8'h59, 32'h0);
    chk(e, 1);
    stream(20);
    for (k = 0; k < 8; k = k + 1) begin
      wcfg({1'b0, k[2], k[1:0] + 2'd1, k[1:0] + 2'd2, k[1:0]});
      apb(1'b0, 8'h60, 32'h0);
      chk(r, {7'h0, lpf});
      wcfg(cfg | 8'h80);
      apb(1'b0, 8'h58, 32'h0);
      chk(r, {24'h0, cfg});
      chk(act, 1);
      apb(1'b1, 8'h5c, 32'h0);
      nout = 0;
      stream(40);
      apb(1'b0, 8'h5c, 32'h0);
      chk(r, {14'h0, 2'b11, nout[15:0]});
      apb(1'b0, 8'h64, 32'h0);
      chk(r, {13'h0, ld});
      apb(1'b0, 8'h68, 32'h0);
      chk(r, {8'h0, lt});
    end
    @(posedge clk_sys_in);
    ce_in <= 1'b0;
    src.send(19'h1234);
    ce_in <= 1'b1;
    wcfg(8'h03);
    wcfg(8'h83);
    ce_in <= 1'b0;
    fork
      apb(1'b0, 8'h58, 32'h0);
      begin
        repeat (2) @(posedge clk_sys_in);
        ce_in <= 1'b1;
      end
    join
    chk(r, {24'h0, cfg});
    stream(40);
    repeat (5) @(posedge clk_sys_in);
    chk(expq.size(), 0);
    report_and_stop;
  end
endmodule // ambient_outlier_replacer_test
